//--- hdl/scp_map.vh
// Constants of the serial control port: field positions, addresses, reset values
`ifndef SCP_MAP_VH
`define SCP_MAP_VH

// Instruction word layout
`define SCP_INSTR_W 16
`define SCP_I_RW 15
`define SCP_I_LEN_HI 14
`define SCP_I_LEN_LO 13
`define SCP_I_ADDR_HI 12
`define SCP_I_ADDR_W 13
`define SCP_INSTR_LAST 4'hf
`define SCP_BYTE_LAST 3'h7

// Length field codes
`define SCP_LEN_ONE 2'h0
`define SCP_LEN_TWO 2'h1
`define SCP_LEN_THREE 2'h2
`define SCP_LEN_STREAM 2'h3

// Register map
`define SCP_ADDR_W 10
`define SCP_REG_COUNT 11'h233
`define SCP_REG_FIRST 10'h000
`define SCP_REG_LAST 10'h232
`define SCP_REG_CONFIG 10'h000
`define SCP_REG_READSEL 10'h004
`define SCP_REG_UPDATE 10'h232

// Bit positions inside registers
`define SCP_BIT_UNIDIR 0
`define SCP_BIT_LSB 1
`define SCP_BIT_READSEL 0
`define SCP_BIT_UPDATE 0
`define SCP_UPDATE_MASK 8'hfe

// Reset values
`define SCP_CFG_RESET 8'h18
`define SCP_READSEL_RESET 1'h0

// Write queue
`define SCP_FIFO_DEPTH 8
`define SCP_FIFO_PW 3

`endif

//--- hdl/scp_regmem.v
// Register map storage with one write port and one registered read port
`timescale 1ns/1ps
module scp_regmem #(
	parameter AW = 10,
	parameter DW = 8,
	parameter DEPTH = 563
) (
	input wire clk_sys_i,
	input wire wr_en_i,
	input wire [AW-1:0] wr_addr_i,
	input wire [DW-1:0] wr_data_i,
	input wire [AW-1:0] rd_addr_i,
	output reg [DW-1:0] rd_data_o
);

reg [DW-1:0] mem_q [0:DEPTH-1];
integer i;

// Contents are not reset; they start cleared in simulation and FPGA images
initial begin
	for (i = 0; i < DEPTH; i = i + 1) begin
		mem_q[i] = {DW{1'b0}};
	end
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge clk_sys_i) begin
	if (wr_en_i) begin
		mem_q[wr_addr_i] <= wr_data_i;
	end
	rd_data_o <= mem_q[rd_addr_i];
end

endmodule // scp_regmem

//--- hdl/scp_fifo.v
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module scp_fifo #(
	parameter W = 18,
	parameter DEPTH = 8,
	parameter PW = 3
) (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o
);

reg [W-1:0] slot_q [0:DEPTH-1];
reg [PW-1:0] wr_ptr_q;
reg [PW-1:0] rd_ptr_q;
reg [PW:0] count_q;
wire push;
wire pop;

assign in_ready_o = (count_q != DEPTH[PW:0]);
assign out_valid_o = (count_q != {(PW+1){1'b0}});
assign out_data_o = slot_q[rd_ptr_q];
assign push = in_valid_i & in_ready_o;
assign pop = out_valid_o & out_ready_i;

////////////////////////////////////////////////////////////////////////////////

always @(posedge clk_sys_i) begin
	if (push) begin
		slot_q[wr_ptr_q] <= in_data_i;
	end
end

always @(posedge clk_sys_i) begin
	if (!reset_n_i) begin
		wr_ptr_q <= {PW{1'b0}};
		rd_ptr_q <= {PW{1'b0}};
		count_q <= {(PW+1){1'b0}};
	end else begin
		if (push) begin
			wr_ptr_q <= (wr_ptr_q == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : wr_ptr_q + 1'b1;
		end
		if (pop) begin
			rd_ptr_q <= (rd_ptr_q == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : rd_ptr_q + 1'b1;
		end
		if (push && !pop) begin
			count_q <= count_q + 1'b1;
		end else if (pop && !push) begin
			count_q <= count_q - 1'b1;
		end
	end
end

endmodule // scp_fifo

//--- hdl/scp_serial_port.v
// Serial control port slave: instruction decode, buffered register map, update copy
`timescale 1ns/1ps
`include "scp_map.vh"

module scp_serial_port #(
	parameter FIFO_DEPTH = `SCP_FIFO_DEPTH
) (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire sclk_i,
	input wire cs_n_i,
	input wire sdio_i,
	output reg sdio_o,
	output reg sdio_oe_o,
	output reg serial_data_out_o,
	output reg serial_data_out_oe_o,
	input wire [`SCP_ADDR_W-1:0] cfg_addr_i,
	output wire [7:0] cfg_data_o,
	output wire update_busy_o,
	output reg write_lost_o
);

localparam ST_INSTR = 3'h1;
localparam ST_DATA = 3'h2;
localparam ST_DONE = 3'h4;
localparam EW = `SCP_ADDR_W + 8;
localparam [7:0] CFG_RST = `SCP_CFG_RESET;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: [0] shift clock, [1] select, [2] data in

reg [2:0] sync1_q, sync2_q;
reg sclk_last_q, cs_last_q;
wire sclk_rise, sclk_fall, cs_n_s, cs_rise, din;

always @(posedge clk_sys_i) begin
	if (!reset_n_i) begin
		sync1_q <= 3'h2;
		sync2_q <= 3'h2;
		sclk_last_q <= 1'h0;
		cs_last_q <= 1'h1;
	end else begin
		sync1_q <= {sdio_i, cs_n_i, sclk_i};
		sync2_q <= sync1_q;
		sclk_last_q <= sync2_q[0];
		cs_last_q <= sync2_q[1];
	end
end

assign sclk_rise = sync2_q[0] & ~sclk_last_q;
assign sclk_fall = ~sync2_q[0] & sclk_last_q;
assign cs_n_s = sync2_q[1];
assign cs_rise = cs_n_s & ~cs_last_q;
assign din = sync2_q[2];

////////////////////////////////////////////////////////////////////////////////
// Port state

reg [2:0] state_q;
reg [3:0] cnt_q;
reg [`SCP_INSTR_W-1:0] instr_q;
reg rd_q, stream_q, unidir_q, lsb_q, rsel_q;
reg rd_pend_q, rd_oob_q, rd_act_q, copy_busy_q, cp_wr_q;
reg [1:0] left_q;
reg [`SCP_I_ADDR_W-1:0] addr_q;
reg [7:0] rx_q, tx_q;
reg [`SCP_ADDR_W-1:0] copy_addr_q, cp_wa_q;

wire [`SCP_INSTR_W-1:0] instr_nx;
wire [7:0] rx_nx, d_data, buf_rdata, act_rdata;
wire bit_ev, instr_end, byte_end, more, rd_req, rd_in_range, wr_in_range;
wire push, fifo_in_ready, d_valid, d_take, copy_step;
wire [`SCP_I_ADDR_W-1:0] addr_nx, rd_addr;
wire [EW-1:0] d_entry;
wire [`SCP_ADDR_W-1:0] d_addr;

// Address range check on a full 13-bit address
function in_range;
	input [`SCP_I_ADDR_W-1:0] a;
	begin
		in_range = (a[`SCP_I_ADDR_HI:`SCP_ADDR_W] == 3'h0) && (a[`SCP_ADDR_W-1:0] <= `SCP_REG_LAST);
	end
endfunction

// Descending steps wrap from the bottom to the top of the map, matching the stop sequence
function [`SCP_I_ADDR_W-1:0] step;
	input [`SCP_I_ADDR_W-1:0] a;
	input lsb;
	begin
		if (lsb) begin
			step = a + 13'h0001;
		end else if (a == 13'h0000) begin
			step = {3'h0, `SCP_REG_LAST};
		end else begin
			step = a - 13'h0001;
		end
	end
endfunction

// Bit order follows the order select for instruction and data alike
assign instr_nx = lsb_q ? {din, instr_q[`SCP_INSTR_W-1:1]} : {instr_q[`SCP_INSTR_W-2:0], din};
assign rx_nx = lsb_q ? {din, rx_q[7:1]} : {rx_q[6:0], din};

assign bit_ev = sclk_rise & ~cs_n_s & (state_q != ST_DONE);
assign instr_end = bit_ev & (state_q == ST_INSTR) & (cnt_q == `SCP_INSTR_LAST);
assign byte_end = bit_ev & (state_q == ST_DATA) & (cnt_q[2:0] == `SCP_BYTE_LAST);
assign more = stream_q ? (addr_q != {3'h0, `SCP_REG_LAST}) : (left_q != 2'h0);
assign addr_nx = step(addr_q, lsb_q);
assign rd_addr = instr_end ? instr_nx[`SCP_I_ADDR_HI:0] : addr_nx;
assign rd_req = (instr_end & instr_nx[`SCP_I_RW]) | (byte_end & rd_q & more);
assign rd_in_range = in_range(rd_addr);
assign wr_in_range = in_range(addr_q);
assign push = byte_end & ~rd_q & wr_in_range;

////////////////////////////////////////////////////////////////////////////////
// Serial state machine

always @(posedge clk_sys_i) begin
	if (!reset_n_i) begin
		state_q <= ST_INSTR;
		cnt_q <= 4'h0;
		instr_q <= 16'h0000;
		rd_q <= 1'h0;
		stream_q <= 1'h0;
		left_q <= 2'h0;
		addr_q <= 13'h0000;
		rx_q <= 8'h00;
		write_lost_o <= 1'h0;
	end else if (cs_rise) begin
		// Mid-byte rise, finished cycle or ended stream: back to idle
		if ((cnt_q[2:0] != 3'h0) || (state_q == ST_DONE) || ((state_q == ST_DATA) && stream_q)) begin
			state_q <= ST_INSTR;
			cnt_q <= 4'h0;
			rd_q <= 1'h0;
		end
		// Otherwise a byte-boundary stall: everything is held
	end else begin
		if (push && !fifo_in_ready) begin
			write_lost_o <= 1'h1;
		end
		if (bit_ev) begin
			case (state_q)
				ST_INSTR: begin
					instr_q <= instr_nx;
					cnt_q <= cnt_q + 4'h1;
					if (instr_end) begin
						rd_q <= instr_nx[`SCP_I_RW];
						stream_q <= ({instr_nx[`SCP_I_LEN_HI], instr_nx[`SCP_I_LEN_LO]} == `SCP_LEN_STREAM);
						left_q <= {instr_nx[`SCP_I_LEN_HI], instr_nx[`SCP_I_LEN_LO]};
						addr_q <= instr_nx[`SCP_I_ADDR_HI:0];
						cnt_q <= 4'h0;
						state_q <= ST_DATA;
					end
				end
				ST_DATA: begin
					rx_q <= rx_nx;
					cnt_q <= {1'b0, cnt_q[2:0] + 3'h1};
					if (byte_end) begin
						if (more) begin
							addr_q <= addr_nx;
							if (!stream_q) begin
								left_q <= left_q - 2'h1;
							end
						end else begin
							state_q <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					cnt_q <= 4'h0;
				end
				default: begin
					state_q <= ST_INSTR;
					cnt_q <= 4'h0;
				end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Readback shifting and pin drive

always @(posedge clk_sys_i) begin
	if (!reset_n_i) begin
		rd_pend_q <= 1'h0;
		rd_oob_q <= 1'h0;
		rd_act_q <= 1'h0;
		tx_q <= 8'h00;
		sdio_o <= 1'h0;
		serial_data_out_o <= 1'h0;
		sdio_oe_o <= 1'h0;
		serial_data_out_oe_o <= 1'h0;
	end else begin
		rd_pend_q <= rd_req;
		if (rd_req) begin
			rd_oob_q <= ~rd_in_range;
			rd_act_q <= rsel_q;
		end
		if (rd_pend_q) begin
			tx_q <= rd_oob_q ? 8'h00 : (rd_act_q ? act_rdata : buf_rdata);
		end else if (sclk_fall && !cs_n_s && (state_q == ST_DATA) && rd_q) begin
			sdio_o <= lsb_q ? tx_q[0] : tx_q[7];
			serial_data_out_o <= lsb_q ? tx_q[0] : tx_q[7];
			tx_q <= lsb_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
		end
		sdio_oe_o <= ~cs_n_s & (state_q == ST_DATA) & rd_q & ~unidir_q;
		serial_data_out_oe_o <= ~cs_n_s & unidir_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Write queue: bytes wait here while an update copy holds the buffer port

scp_fifo #(
	.W(EW),
	.DEPTH(FIFO_DEPTH),
	.PW(`SCP_FIFO_PW)
) u_fifo (
	.clk_sys_i(clk_sys_i),
	.reset_n_i(reset_n_i),
	.in_valid_i(push),
	.in_ready_o(fifo_in_ready),
	// The last bit lands in rx_q on this same edge, so queue the next value
	.in_data_i({addr_q[`SCP_ADDR_W-1:0], rx_nx}),
	.out_valid_o(d_valid),
	.out_ready_i(~copy_busy_q),
	.out_data_o(d_entry)
);

assign d_addr = d_entry[EW-1:8];
assign d_data = d_entry[7:0];
assign d_take = d_valid & ~copy_busy_q;
// A serial read of the buffer pauses the copy so neither sees the other's data
assign copy_step = copy_busy_q & ~(rd_req & ~rsel_q);
assign update_busy_o = copy_busy_q;

always @(posedge clk_sys_i) begin
	if (!reset_n_i) begin
		unidir_q <= CFG_RST[`SCP_BIT_UNIDIR];
		lsb_q <= CFG_RST[`SCP_BIT_LSB];
		rsel_q <= `SCP_READSEL_RESET;
		copy_busy_q <= 1'h0;
		copy_addr_q <= `SCP_REG_FIRST;
		cp_wr_q <= 1'h0;
		cp_wa_q <= `SCP_REG_FIRST;
	end else begin
		// Port configuration acts at once, without waiting for an update
		if (d_take && (d_addr == `SCP_REG_CONFIG)) begin
			unidir_q <= d_data[`SCP_BIT_UNIDIR];
			lsb_q <= d_data[`SCP_BIT_LSB];
		end
		if (d_take && (d_addr == `SCP_REG_READSEL)) begin
			rsel_q <= d_data[`SCP_BIT_READSEL];
		end
		if (d_take && (d_addr == `SCP_REG_UPDATE) && d_data[`SCP_BIT_UPDATE]) begin
			copy_busy_q <= 1'h1;
			copy_addr_q <= `SCP_REG_FIRST;
		end
		cp_wr_q <= copy_step;
		if (copy_step) begin
			cp_wa_q <= copy_addr_q;
			if (copy_addr_q == `SCP_REG_LAST) begin
				copy_busy_q <= 1'h0;
			end else begin
				copy_addr_q <= copy_addr_q + 10'h001;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Buffer and active register storage

scp_regmem #(
	.AW(`SCP_ADDR_W),
	.DW(8),
	.DEPTH(`SCP_REG_COUNT)
) u_buffer (
	.clk_sys_i(clk_sys_i),
	.wr_en_i(d_take),
	.wr_addr_i(d_addr),
	.wr_data_i((d_addr == `SCP_REG_UPDATE) ? (d_data & `SCP_UPDATE_MASK) : d_data),
	.rd_addr_i((rd_req & ~rsel_q) ? rd_addr[`SCP_ADDR_W-1:0] : copy_addr_q),
	.rd_data_o(buf_rdata)
);

scp_regmem #(
	.AW(`SCP_ADDR_W),
	.DW(8),
	.DEPTH(`SCP_REG_COUNT)
) u_active (
	.clk_sys_i(clk_sys_i),
	.wr_en_i(cp_wr_q),
	.wr_addr_i(cp_wa_q),
	.wr_data_i(buf_rdata),
	.rd_addr_i((rd_req & rsel_q) ? rd_addr[`SCP_ADDR_W-1:0] : cfg_addr_i),
	.rd_data_o(act_rdata)
);

assign cfg_data_o = act_rdata;

endmodule // scp_serial_port

//--- verif/scp_serial_port_chk.sv
// Assertions on the serial control port pins and status outputs
`timescale 1ns/1ps
module scp_serial_port_chk (
	input logic clk_sys_i,
	input logic reset_n_i,
	input logic sclk_i,
	input logic cs_n_i,
	input logic sdio_o,
	input logic sdio_oe_o,
	input logic serial_data_out_o,
	input logic serial_data_out_oe_o,
	input logic update_busy_o,
	input logic write_lost_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	// Copy length; reads pause the copy, so the bound leaves room for them
	logic [11:0] busy_cnt_q;
	always @(posedge clk_sys_i) begin
		if (!reset_n_i || !update_busy_o) busy_cnt_q <= 12'h000;
		else busy_cnt_q <= busy_cnt_q + 12'h001;
	end
	////////////////////////////////////////////////////////////////
	pins_released_a: assert property (cs_n_i [*5] |-> !sdio_oe_o && !serial_data_out_oe_o)
		else $error("data pin driven while deselected");
	one_driver_a: assert property (sdio_oe_o |-> !serial_data_out_oe_o)
		else $error("both data pins driven");
	same_bit_a: assert property (sdio_oe_o |-> sdio_o == serial_data_out_o)
		else $error("pins carry different bits");
	launch_hold_a: assert property ($rose(sclk_i) && sdio_oe_o |=> $stable(sdio_o) [*2])
		else $error("read bit moved near rising shift clock");
	reset_quiet_a: assert property ($rose(reset_n_i) |-> !sdio_oe_o && !serial_data_out_oe_o && !update_busy_o
		&& !write_lost_o)
		else $error("outputs not cleared by reset");
	oe_cause_a: assert property ($rose(sdio_oe_o) |-> !cs_n_i && !$past(cs_n_i, 2))
		else $error("shared pin driven without select");
	lost_sticky_a: assert property (write_lost_o |=> write_lost_o)
		else $error("lost flag cleared");
	copy_min_a: assert property ($rose(update_busy_o) |-> update_busy_o [*8])
		else $error("update copy too short");
	copy_max_a: assert property (busy_cnt_q < 12'h7d0)
		else $error("update copy never ends");
	cover property ($rose(update_busy_o));
	cover property ($rose(sdio_oe_o));
	cover property ($rose(serial_data_out_oe_o));
endmodule // scp_serial_port_chk

bind scp_serial_port scp_serial_port_chk u_chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i),
	.cs_n_i(cs_n_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .serial_data_out_o(serial_data_out_o),
	.serial_data_out_oe_o(serial_data_out_oe_o), .update_busy_o(update_busy_o), .write_lost_o(write_lost_o));

//--- verif/scp_host_model.sv
// Host side model: shift clock, chip select and shared data line
`timescale 1ns/1ps
module scp_host_model (
	input logic clk_sys_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic line_o,
	input logic dev_sdio_i,
	input logic dev_sdio_oe_i,
	input logic dev_sdo_i,
	input logic dev_sdo_oe_i
);
	logic drv_q = 1'b0;
	logic bit_q = 1'b0;
	logic last_q = 1'b0;
	logic uni = 1'b0;
	logic lsbf = 1'b0;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
	end
	// Undriven line flips every cycle so a stale bit never passes for data
	assign line_o = dev_sdio_oe_i ? dev_sdio_i : (drv_q ? bit_q : ~last_q);
	always @(posedge clk_sys_i) begin
		last_q <= line_o;
	end
	////////////////////////////////////////////////////////////////
	task csv(input logic v);
		@(posedge clk_sys_i);
		sclk_o <= 1'b0;
		drv_q <= 1'b0;
		cs_n_o <= v;
		repeat (8) @(posedge clk_sys_i);
	endtask
	task stall;
		csv(1'b1);
		csv(1'b0);
	endtask
	// Sends n bits, MSB first unless lsbf; fewer than 8 makes a partial byte
	task automatic xbyte(input logic [7:0] d, input logic drv, input int n, output logic [7:0] r);
		int i;
		int k;
		r = 8'h00;
		for (i = 7; i > 7 - n; i--) begin
			k = lsbf ? 7 - i : i;
			@(posedge clk_sys_i);
			sclk_o <= 1'b0;
			bit_q <= d[k];
			drv_q <= drv;
			repeat (4) @(posedge clk_sys_i);
			sclk_o <= 1'b1;
			@(posedge clk_sys_i);
			r[k] = uni ? (dev_sdo_oe_i ? dev_sdo_i : ~last_q) : line_o;
			repeat (2) @(posedge clk_sys_i);
		end
	endtask
endmodule // scp_host_model

//--- verif/serial_control_port_slave_tb_top.sv
// Self-checking bench for the serial control port slave
`timescale 1ns/1ps
module serial_control_port_slave_tb_top;
	logic clk_sys_i;
	logic reset_n_i;
	logic [9:0] cfg_addr_i;
	wire sclk, cs_n, line, sdio_o, sdio_oe, serial_data_out, sdo_oe, busy, lost;
	wire [7:0] cfg_data_o;
	logic [7:0] wb [0:3];
	logic [7:0] rb [0:3];
	logic [7:0] r;
	int num_errors = 0;
	int checks = 0;
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	scp_serial_port dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(line),
		.sdio_o(sdio_o), .sdio_oe_o(sdio_oe), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(sdo_oe),
		.cfg_addr_i(cfg_addr_i), .cfg_data_o(cfg_data_o), .update_busy_o(busy), .write_lost_o(lost));
	scp_host_model host (.clk_sys_i(clk_sys_i), .sclk_o(sclk), .cs_n_o(cs_n), .line_o(line), .dev_sdio_i(sdio_o),
		.dev_sdio_oe_i(sdio_oe), .dev_sdo_i(serial_data_out), .dev_sdo_oe_i(sdo_oe));
	////////////////////////////////////////////////////////////////
	task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			num_errors++;
		end
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	function automatic [15:0] ins(input logic rd, input logic [1:0] len, input logic [9:0] a);
		ins = {rd, len, 3'h0, a};
	endfunction
	// One framed transfer; st names the byte after which select parks high, 0 = first instruction byte
	task automatic sess(input logic [15:0] w, input int n, input int st);
		int i;
		host.csv(1'b0);
		host.xbyte(host.lsbf ? w[7:0] : w[15:8], 1'b1, 8, r);
		if (st == 0) host.stall();
		host.xbyte(host.lsbf ? w[15:8] : w[7:0], 1'b1, 8, r);
		for (i = 0; i < n; i++) begin
			host.xbyte(wb[i], !w[15], 8, rb[i]);
			if (st == i + 1) host.stall();
		end
		host.csv(1'b1);
	endtask
	task automatic wr1(input logic [9:0] a, input logic [7:0] d);
		wb[0] = d;
		sess(ins(1'b0, 2'h0, a), 1, -1);
	endtask
	task automatic wait_copy;
		int i;
		for (i = 0; i < 60 && busy !== 1'b1; i++) @(posedge clk_sys_i);
		for (i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk_sys_i);
		if (busy !== 1'b0) begin
			$display("ERROR update_busy expected 0 seen %b", busy);
			num_errors++;
			give_verdict();
		end
		repeat (3) @(posedge clk_sys_i);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		reset_n_i <= 1'b0;
		cfg_addr_i <= 10'h000;
		repeat (20) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		wb[0] = 8'ha1;
		wb[1] = 8'ha2;
		wb[2] = 8'ha3;
		sess(ins(1'b0, 2'h2, 10'h012), 3, 1);
		sess(ins(1'b1, 2'h2, 10'h012), 3, 0);
		cmp("rd012", 8'ha1, rb[0]);
		cmp("rd011", 8'ha2, rb[1]);
		cmp("rd010", 8'ha3, rb[2]);
		cfg_addr_i <= 10'h011;
		repeat (3) @(posedge clk_sys_i);
		cmp("act011", 8'h00, cfg_data_o);
		// Select rises mid-byte: the partial byte must vanish
		host.csv(1'b0);
		host.xbyte(8'h00, 1'b1, 8, r);
		host.xbyte(8'h10, 1'b1, 8, r);
		host.xbyte(8'hff, 1'b1, 4, r);
		host.csv(1'b1);
		// Stalled transfer abandoned with a short partial byte
		host.csv(1'b0);
		host.xbyte(8'h20, 1'b1, 8, r);
		host.xbyte(8'h11, 1'b1, 8, r);
		host.stall();
		host.xbyte(8'hff, 1'b1, 3, r);
		host.csv(1'b1);
		sess(ins(1'b1, 2'h1, 10'h011), 2, -1);
		cmp("abort011", 8'ha2, rb[0]);
		cmp("drop010", 8'ha3, rb[1]);
		wr1(10'h232, 8'h01);
		wait_copy();
		cmp("upd011", 8'ha2, cfg_data_o);
		sess(ins(1'b1, 2'h0, 10'h232), 1, -1);
		cmp("selfclr", 8'h00, rb[0]);
		wr1(10'h004, 8'h01);
		wr1(10'h012, 8'h5a);
		sess(ins(1'b1, 2'h0, 10'h012), 1, -1);
		cmp("active012", 8'ha1, rb[0]);
		wr1(10'h004, 8'h00);
		wb[0] = 8'h3c;
		wb[1] = 8'hc3;
		wb[2] = 8'h99;
		sess(ins(1'b0, 2'h3, 10'h002), 3, -1);
		host.uni = 1'b1;
		sess(ins(1'b1, 2'h3, 10'h002), 4, -1);
		cmp("st002", 8'h3c, rb[0]);
		cmp("st001", 8'hc3, rb[1]);
		cmp("st000", 8'h99, rb[2]);
		cmp("st232", 8'h00, rb[3]);
		// Mirrored config byte: LSB first, shared pin again
		wr1(10'h000, 8'h5a);
		host.uni = 1'b0;
		host.lsbf = 1'b1;
		wb[0] = 8'h11;
		wb[1] = 8'h22;
		sess(ins(1'b0, 2'h1, 10'h010), 2, -1);
		sess(ins(1'b1, 2'h1, 10'h010), 2, -1);
		cmp("lsb010", 8'h11, rb[0]);
		cmp("lsb011", 8'h22, rb[1]);
		sess(ins(1'b1, 2'h0, 10'h233), 1, -1);
		cmp("oob233", 8'h00, rb[0]);
		cmp("lost", 8'h00, {7'h00, lost});
		give_verdict();
	end
endmodule // serial_control_port_slave_tb_top
